// [hdl/smwp_core.sv]
// Purpose: Status register, write-enable latch and array write gating.
// Assumes: Instruction decode happens upstream and arrives as one-cycle strobes.
// Notes:   Reset stands for power-up; all protection state is volatile.
//
// Contract
// - Only the low address bits of the selected density are used; upper bits are zero.
// - Every status bit loads its default of zero on initialization.
// - Status contents are volatile and return to default after power returns.
// - Bit 7 enables pin protection: low pin blocks status writes when set.
// - Bit 5 set takes the protected block from the lowest addresses.
// - Bit 5 clear takes the protected block from the top of the density.
// - Bits 4 to 2 form the three-bit protection level field.
// - Top mode protects none, 1/64 up to 1/2, or the whole array.
// - Bottom mode protects the same fractions starting at address zero.
// - Bit 1 is the read-only write-enable latch; one permits writes.
// - Status writes need the latch set and pin protection off or pin high.
// - Protected addresses never write; others need only the latch set.
// - Bits 6 and 0 are reserved, read zero and ignore writes.
// - Write-enable instruction sets the latch; host issues it before writes.
// - Latch clears at end of any write instruction and on write disable.
`timescale 1ns/1ns

module smwp_core
   import smwp_pkg::*;
#(
   parameter logic [1:0] DENSITY = DENS_16MB
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Pin
   input  wire logic              wp_n,
   // Instruction strobes
   input  wire logic              write_enable_cmd,
   input  wire logic              write_disable_instruction,
   input  wire logic              sr_write,
   input  wire logic [SR_W-1:0]   sr_wdata,
   input  wire smwp_req_t         array_write,
   input  wire logic              write_end,
   // Results
   output logic [SR_W-1:0]        status_rdata,
   output logic                   array_write_ok,
   output logic [ADDR_W-1:0]      array_write_addr,
   output logic                   array_protected
);

   ////////////////////////////////////////////////////////////////////////////
   // Holds every piece of state in one register.

   typedef struct packed
   {
      smwp_sr_t          sr;
      logic              ok;
      logic [ADDR_W-1:0] addr;
      logic              prot;
   } smwp_state_t;

   localparam smwp_state_t S_RESET =
      '{
         sr:   smwp_sr_t'(SR_RESET),
         ok:   1'b0,
         addr: '0,
         prot: 1'b0
      };

   smwp_state_t       s_q;
   smwp_state_t       s_d;
   logic [ADDR_W-1:0] eff_addr;
   logic              hit;
   logic              sr_open;
   logic              arr_open;
   logic              wel_clear;
   logic              wel_set;

   ////////////////////////////////////////////////////////////////////////////
   // Refuses parameter values that the decode cannot serve.

   if ((DENSITY > DENS_16MB) || (ADDR_W <= BITS_16MB) || (SR_W != $bits(smwp_sr_t)))
   begin
      $error("Unsupported density or register layout");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decodes the address map of the density.

   // Returns the number of addressable bits for a density code.
   function automatic int dens_bits(input logic [1:0] d);
      unique case (d)
         DENS_1MB:
         begin
            dens_bits = BITS_1MB;
         end
         DENS_4MB:
         begin
            dens_bits = BITS_4MB;
         end
         DENS_8MB:
         begin
            dens_bits = BITS_8MB;
         end
         DENS_16MB:
         begin
            dens_bits = BITS_16MB;
         end
      endcase
   endfunction

   // Returns the highest address of the configured density.
   function automatic logic [ADDR_W-1:0] dens_last();
      logic [ADDR_W:0] span;
      span      = (ADDR_W+1)'(1) << dens_bits(DENSITY);
      dens_last = ADDR_W'(span - (ADDR_W+1)'(1));
   endfunction

   // Clears address bits above the density.
   function automatic logic [ADDR_W-1:0] mask_addr(input logic [ADDR_W-1:0] a);
      mask_addr = a & dens_last();
   endfunction

   // Returns the size of the protected block for a level code.
   function automatic logic [ADDR_W-1:0] level_size(input logic [2:0] lvl);
      logic [ADDR_W:0] span;
      span = (ADDR_W+1)'(1) << dens_bits(DENSITY);
      if (lvl == BP_NONE)
      begin
         level_size = '0;
      end
      else if (lvl == BP_ALL)
      begin
         level_size = ADDR_W'(span);
      end
      else
      begin
         level_size = ADDR_W'(span >> (BP_SHIFT_BASE - int'(lvl)));
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Locates an address against the protected block.

   // Tests for the block that ends at the top address of the density.
   function automatic logic top_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] size);
      top_hit = (a > (dens_last() - size));
   endfunction

   // Tests for the block that starts at address zero.
   function automatic logic bottom_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] size);
      bottom_hit = (a < size);
   endfunction

   // Tests whether an address lies in the protected block.
   function automatic logic in_block(input logic [ADDR_W-1:0] a,
                                     input logic              bottom,
                                     input logic [2:0]        lvl);
      logic [ADDR_W-1:0] size;
      size = level_size(lvl);
      if (lvl == BP_NONE)
      begin
         in_block = 1'b0;
      end
      else if (lvl == BP_ALL)
      begin
         in_block = 1'b1;
      end
      else if (bottom)
      begin
         in_block = bottom_hit(a, size);
      end
      else
      begin
         in_block = top_hit(a, size);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Grants write permission.

   // Decides whether the status register may be written.
   function automatic logic sr_writable(input logic wel,
                                        input logic pin_en,
                                        input logic pin);
      unique case ({wel, pin_en, pin})
         3'h0:
         begin
            sr_writable = 1'b0;
         end
         3'h1:
         begin
            sr_writable = 1'b0;
         end
         3'h2:
         begin
            sr_writable = 1'b0;
         end
         3'h3:
         begin
            sr_writable = 1'b0;
         end
         3'h4:
         begin
            sr_writable = 1'b1;
         end
         3'h5:
         begin
            sr_writable = 1'b1;
         end
         3'h6:
         begin
            sr_writable = 1'b0;
         end
         3'h7:
         begin
            sr_writable = 1'b1;
         end
      endcase
   endfunction

   // Decides whether an array address may be written; the pin plays no part.
   function automatic logic arr_writable(input logic wel,
                                         input logic in_blk);
      unique case ({wel, in_blk})
         2'h0:
         begin
            arr_writable = 1'b0;
         end
         2'h1:
         begin
            arr_writable = 1'b0;
         end
         2'h2:
         begin
            arr_writable = 1'b1;
         end
         2'h3:
         begin
            arr_writable = 1'b0;
         end
      endcase
   endfunction

   // Loads the writable status fields and keeps the rest.
   function automatic smwp_sr_t sr_merge(input smwp_sr_t        old,
                                         input logic [SR_W-1:0] wdata);
      smwp_sr_t nxt;
      nxt                     = old;
      nxt.hw_protect_en       = wdata[SR_HW_EN_BIT];
      nxt.top_bottom_select   = wdata[SR_TB_BIT];
      nxt.block_protect_level = wdata[SR_BP_HI_BIT:SR_BP_LO_BIT];
      sr_merge                = nxt;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Computes the next state.

   always_comb
   begin
      s_d       = s_q;
      eff_addr  = mask_addr(array_write.addr);
      hit       = in_block(eff_addr, s_q.sr.top_bottom_select,
                           s_q.sr.block_protect_level);
      sr_open   = sr_writable(s_q.sr.write_enable_latch, s_q.sr.hw_protect_en, wp_n);
      arr_open  = arr_writable(s_q.sr.write_enable_latch, hit);
      wel_clear = write_end || write_disable_instruction;
      wel_set   = write_enable_cmd;

      // Reports the array write decision and the decoded address.
      s_d.ok   = array_write.valid && arr_open;
      s_d.addr = eff_addr;
      s_d.prot = hit;

      // Loads the status register; a refused write leaves it unchanged.
      if (sr_write && sr_open)
      begin
         s_d.sr = sr_merge(s_q.sr, sr_wdata);
      end
      s_d.sr.rsvd6 = 1'b0;
      s_d.sr.rsvd0 = 1'b0;

      // Updates the latch; a clear beats a set in the same cycle.
      if (wel_clear)
      begin
         s_d.sr.write_enable_latch = 1'b0;
      end
      else if (wel_set)
      begin
         s_d.sr.write_enable_latch = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers the state; reset stands for power-up.

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_q <= S_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Drives every output straight from the state register.

   assign status_rdata     = s_q.sr;
   assign array_write_ok   = s_q.ok;
   assign array_write_addr = s_q.addr;
   assign array_protected  = s_q.prot;

endmodule

// [hdl/smwp_pkg.sv]
// Purpose: Shared constants and types for the memory write protection block.
// Assumes: Status register layout is eight bits, one register.
// Notes:   Density codes select the number of addressable low address bits.
package smwp_pkg;

   localparam int          ADDR_W        = 24;
   localparam int          SR_W          = 8;
   localparam logic [7:0]  SR_RESET      = 8'h00;
   localparam int          SR_HW_EN_BIT  = 7;
   localparam int          SR_RSVD6_BIT  = 6;
   localparam int          SR_TB_BIT     = 5;
   localparam int          SR_BP_HI_BIT  = 4;
   localparam int          SR_BP_LO_BIT  = 2;
   localparam int          SR_WEL_BIT    = 1;
   localparam int          SR_RSVD0_BIT  = 0;
   localparam logic [7:0]  SR_WR_MASK    = 8'hBC;

   localparam logic [1:0]  DENS_1MB      = 2'h0;
   localparam logic [1:0]  DENS_4MB      = 2'h1;
   localparam logic [1:0]  DENS_8MB      = 2'h2;
   localparam logic [1:0]  DENS_16MB     = 2'h3;
   localparam int          BITS_1MB      = 17;
   localparam int          BITS_4MB      = 19;
   localparam int          BITS_8MB      = 20;
   localparam int          BITS_16MB     = 21;

   localparam logic [2:0]  BP_NONE       = 3'h0;
   localparam logic [2:0]  BP_ALL        = 3'h7;
   localparam int          BP_SHIFT_BASE = 7;

   typedef struct packed
   {
      logic       hw_protect_en;
      logic       rsvd6;
      logic       top_bottom_select;
      logic [2:0] block_protect_level;
      logic       write_enable_latch;
      logic       rsvd0;
   } smwp_sr_t;

   typedef struct packed
   {
      logic                 valid;
      logic [ADDR_W-1:0]    addr;
   } smwp_req_t;

endpackage

// [verification/smwp_core_checker.sv]
// Purpose: Port assertions for the protection block.
// Assumes: Bound to every core instance.
// Notes:   Results follow strobes by one cycle.
`timescale 1ns/1ns
module smwp_core_checker
   import smwp_pkg::*;
#(
   parameter logic [1:0] DENSITY = DENS_16MB
)
(
   // Clock and reset
   input wire logic            clk,
   input wire logic            rst_n,
   // Inputs
   input wire logic            wp_n,
   input wire logic            write_enable_cmd,
   input wire logic            write_disable_instruction,
   input wire logic            sr_write,
   input wire logic [7:0]      sr_wdata,
   input wire smwp_req_t       array_write,
   input wire logic            write_end,
   // Outputs
   input wire logic [7:0]      status_rdata,
   input wire logic            array_write_ok,
   input wire logic [23:0]     array_write_addr,
   input wire logic            array_protected
);
   localparam int AB = DENSITY == DENS_16MB ? BITS_16MB : DENSITY == DENS_8MB ? BITS_8MB :
                       DENSITY == DENS_4MB ? BITS_4MB : BITS_1MB;
   logic lock;
   assign lock = !status_rdata[1] || (status_rdata[7] && !wp_n);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_sr_reset: assert property ($rose(rst_n) |-> status_rdata == 8'h00)
      else $error("status not default");
   a_rsvd_zero: assert property (!status_rdata[6] && !status_rdata[0])
      else $error("reserved bit set");
   a_addr_mask: assert property (array_write.valid |=>
      array_write_addr == ($past(array_write.addr) & ((24'h1 << AB) - 24'h1)))
      else $error("address not masked");
   a_ok_gate: assert property (array_write_ok |-> $past(array_write.valid) &&
      $past(status_rdata[1]) && !array_protected) else $error("bad write ok");
   a_wel_set: assert property (write_enable_cmd && !write_end && !write_disable_instruction
      |=> status_rdata[1]) else $error("latch not set");
   a_wel_clear: assert property (write_end || write_disable_instruction |=> !status_rdata[1])
      else $error("latch not cleared");
   a_sr_locked: assert property (sr_write && lock |=> $stable(status_rdata[7:2]))
      else $error("locked status changed");
   a_sr_load: assert property (sr_write && !lock |=> status_rdata[7:2] ==
      {$past(sr_wdata[7]), 1'h0, $past(sr_wdata[5:2])}) else $error("status not loaded");
   c_ok: cover property (array_write_ok);
   c_prot: cover property (array_protected);
   c_pin: cover property (sr_write && status_rdata[7] && !wp_n);
endmodule
bind smwp_core smwp_core_checker #(.DENSITY(DENSITY)) u_chk (.*);

// [verification/smwp_host.sv]
// Purpose: Host model issuing instruction strobes and the pin.
// Assumes: One operation per call, launched on falling edges.
// Notes:   A released address shows its inverse.
`timescale 1ns/1ns
module smwp_host
   import smwp_pkg::*;
(
   // Clock
   input wire logic  clk,
   // Strobes and pin
   output logic      wp_n,
   output logic      we_pulse,
   output logic      wd_pulse,
   output logic      sr_wr,
   output logic [7:0] sr_d,
   output smwp_req_t req,
   output logic      wend
);
   logic pin = 1'h1;
   assign wp_n = pin;
   initial {we_pulse, wd_pulse, sr_wr, sr_d, req, wend} = '0;
   task automatic op(input logic [4:0] k, input logic [23:0] v);
      @(negedge clk);
      {we_pulse, wd_pulse, sr_wr, req.valid, wend} = k;
      sr_d = v[7:0];
      req.addr = v;
      @(negedge clk);
      {we_pulse, wd_pulse, sr_wr, req.valid, wend} = 5'h00;
      sr_d = ~v[7:0];
      req.addr = ~v;
   endtask
endmodule

// [verification/smwp_core_tb_top.sv]
// Purpose: Self-checking bench for the protection block.
// Assumes: Default sixteen megabit density.
// Notes:   Rows hold status value, address and protected flag.
`timescale 1ns/1ns
module smwp_core_tb_top
   import smwp_pkg::*;
;
   localparam logic [4:0] EN = 5'h10, DI = 5'h08, SR = 5'h05, AW = 5'h02, ED = 5'h01;
   logic clk, rst_n, wp_n, we_pulse, wd_pulse, sr_wr, wend, ok, prot;
   logic [7:0] sr_d, sr_q;
   logic [23:0] wa;
   smwp_req_t req;
   int fails = 0;
   int checks_done = 0;
   logic [32:0] rows [13] = '{{8'h04, 24'h1F8000, 1'h1}, {8'h04, 24'h1F7FFF, 1'h0},
      {8'h08, 24'h1F0000, 1'h1}, {8'h0C, 24'h1DFFFF, 1'h0}, {8'h18, 24'h100000, 1'h1},
      {8'h18, 24'h0FFFFF, 1'h0}, {8'h24, 24'h007FFF, 1'h1}, {8'h24, 24'h008000, 1'h0},
      {8'h34, 24'h07FFFF, 1'h1}, {8'h3C, 24'h1FFFFF, 1'h1}, {8'h1C, 24'h000000, 1'h1},
      {8'h10, 24'hE1C000, 1'h0}, {8'h00, 24'h1FFFFF, 1'h0}};
   smwp_host host (.clk(clk), .wp_n(wp_n), .we_pulse(we_pulse), .wd_pulse(wd_pulse),
      .sr_wr(sr_wr),
      .sr_d(sr_d), .req(req), .wend(wend));
   smwp_core u_dut (.clk(clk), .rst_n(rst_n), .wp_n(wp_n), .write_enable_cmd(we_pulse),
      .write_disable_instruction(wd_pulse), .sr_write(sr_wr), .sr_wdata(sr_d),
      .array_write(req),
      .write_end(wend), .status_rdata(sr_q), .array_write_ok(ok), .array_write_addr(wa),
      .array_protected(prot));
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      checks_done++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("fails %0d checks %0d", fails, checks_done);
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      #30000;
      fails++;
      print_verdict();
   end
   initial
   begin
      rst_n = 1'h0;
      repeat (5) @(negedge clk);
      rst_n = 1'h1;
      chk("status", 24'h0, sr_q);
      foreach (rows[i])
      begin
         host.op(EN, 24'h0);
         host.op(SR, rows[i][32:25]);
         chk("status", rows[i][32:25], sr_q);
         host.op(EN, 24'h0);
         host.op(AW, rows[i][24:1]);
         chk("prot", rows[i][0], prot);
         chk("ok", !rows[i][0], ok);
         chk("addr", {3'h0, rows[i][21:1]}, wa);
         host.op(ED, 24'h0);
      end
      host.op(SR, 24'hFF);
      chk("status", 24'h0, sr_q);
      host.op(AW, 24'h10);
      chk("ok", 24'h0, ok);
      host.op(EN, 24'h0);
      host.op(SR, 24'hFF);
      chk("status", 24'hBC, sr_q);
      host.op(EN, 24'h0);
      host.op(SR, 24'h80);
      host.pin = 1'h0;
      host.op(EN, 24'h0);
      host.op(SR, 24'h04);
      chk("status", 24'h80, sr_q);
      host.op(EN, 24'h0);
      host.op(AW, 24'h10);
      chk("ok", 24'h1, ok);
      host.op(DI, 24'h0);
      chk("status", 24'h80, sr_q);
      rst_n = 1'h0;
      @(negedge clk);
      rst_n = 1'h1;
      chk("status", 24'h0, sr_q);
      print_verdict();
   end
endmodule
